// File: common/tcd_consts.svh
// Purpose: Offsets, field positions, reset values of the threshold compare block
// Assumes: 16-bit registers addressed by word index
// Notes:
// How it works
// - Standby bit makes main comparator watch current
// - Four 2-bit mode fields, resets 3,1,2,0
// - Hysteretic: set above high, clear at/below low
// - Window: high strictly between low and high
// - Above: high when sample exceeds high limit
// - Below: high when sample at/below high
// - Invalid code 00 forced level, 01 filter
// - Code 10 inverts output once at entry
// - Code 11 freezes output at entry value
// - Bit 3 gives forced level, reset zero
// - Ratio codes bypass, 2, 4, 8
// - Enable bit decimates into separate register
// - Limit pair: low 15:8, high 7:0
// - Sample at/below low clears output
// - Sample above high sets output
// - Limit resets 0x5A/0xAA and 0xCC/0xCC
// - Main path off forces main result low
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH

`define TCD_OFF_CTRL        10'h002
`define TCD_OFF_MAIN_THR    10'h003
`define TCD_OFF_WARN1_THR   10'h004
`define TCD_OFF_RAW_SAMPLE  10'h00E
`define TCD_OFF_DEC_SAMPLE  10'h00F

`define TCD_RST_CTRL        16'h3610
`define TCD_RST_MAIN_THR    16'h5AAA
`define TCD_RST_WARN1_THR   16'hCCCC
`define TCD_CTRL_WMASK      16'h7FFF

`define TCD_POS_STANDBY     14
`define TCD_POS_WARN3_MODE  12
`define TCD_POS_WARN2_MODE  10
`define TCD_POS_WARN1_MODE  8
`define TCD_POS_MAIN_MODE   6
`define TCD_POS_INV_MODE    4
`define TCD_POS_FORCE_LVL   3
`define TCD_POS_DEC_RATIO   1
`define TCD_POS_DEC_ON      0

`endif

// File: common/tcd_pkg.sv
// Purpose: Types shared by the threshold compare block
// Assumes: 8-bit samples and limits
// Notes: Limit pair layout matches the register (low in upper byte)
package tcd_pkg;

  typedef enum logic [1:0] {
    TCD_HYST   = 2'h0,
    TCD_WINDOW = 2'h1,
    TCD_ABOVE  = 2'h2,
    TCD_BELOW  = 2'h3
  } tcd_cmp_mode_t;

  typedef enum logic [1:0] {
    TCD_INV_FORCE  = 2'h0,
    TCD_INV_FILTER = 2'h1,
    TCD_INV_TOGGLE = 2'h2,
    TCD_INV_HOLD   = 2'h3
  } tcd_inv_mode_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } tcd_limits_t;

  typedef struct packed {
    logic [7:0] value;
    logic       valid;
  } tcd_sample_t;

endpackage : tcd_pkg

// File: dv/tcd_ctrl_properties.sv
// Purpose: Port assertions for tcd_ctrl
// Assumes: Shadows follow accepted writes
// Notes: Limits kept with low not above high
`timescale 1ns/10ps
`default_nettype none
module tcd_ctrl_properties
  import tcd_pkg::*;
(
  // Clock, reset, writes
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [9:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        cfg_unlocked,
  // Channel
  input wire tcd_sample_t adc_in,
  input wire logic        invalid_mode,
  input wire logic        main_path_on,
  input wire logic        channel_digital_output,
  input wire logic        main_compare_out
);
  logic [15:0] c;
  logic [15:0] t;
  logic        go;
  logic [7:0]  v;
  assign go = adc_in.valid && !c[14];
  assign v = adc_in.value;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c <= 16'h3610;
      t <= 16'h5AAA;
    end else if (reg_wr && cfg_unlocked) begin
      if (reg_addr == 10'h002) c <= reg_wdata;
      if (reg_addr == 10'h003) t <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_path_off: assert property (!main_path_on |-> !main_compare_out)
    else $error("path off");
  chk_above_mode: assert property (go && c[7:6] == 2'h2 ##1 main_path_on |->
    main_compare_out == $past(v > t[7:0])) else $error("above mode");
  chk_below_mode: assert property (go && c[7:6] == 2'h3 ##1 main_path_on |->
    main_compare_out == $past(v <= t[7:0])) else $error("below mode");
  chk_hyst_set: assert property (go && c[7:6] == 2'h0 && v > t[7:0] ##1 main_path_on |->
    main_compare_out) else $error("hyst set");
  chk_hyst_clear: assert property (go && c[7:6] == 2'h0 && v <= t[15:8] |=>
    !main_compare_out) else $error("hyst clear");
  chk_force_level: assert property (invalid_mode && c[5:4] == 2'h0 |=>
    channel_digital_output == $past(c[3])) else $error("forced level");
  chk_hold_frozen: assert property (invalid_mode && c[5:4] == 2'h3 |=>
    $stable(channel_digital_output)) else $error("hold moved");
  chk_toggle_entry: assert property ($rose(invalid_mode) && c[5:4] == 2'h2 |=>
    $changed(channel_digital_output)) else $error("no toggle");
  chk_valid_follow: assert property (!invalid_mode |=>
    channel_digital_output == $past(main_compare_out)) else $error("dout not main");
endmodule : tcd_ctrl_properties
`default_nettype wire

// File: dv/tcd_host_model.sv
// Purpose: Host register master
// Assumes: Caller gives the lock state
// Notes: One-cycle strobes, data inverted once released
`timescale 1ns/10ps
`default_nettype none
module tcd_host_model (
  // Register bus
  input  wire logic        mclk,
  output var  logic [9:0]  reg_addr = 10'h000,
  output var  logic        reg_wr = 1'b0,
  output var  logic [15:0] reg_wdata = 16'h0000,
  output var  logic        reg_rd = 1'b0,
  output var  logic        cfg_unlocked = 1'b0
);
  task automatic acc(input logic [9:0] a, input logic [15:0] d, input logic w, input logic u);
    @(posedge mclk);
    #1;
    cfg_unlocked = u;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
  endtask : acc
endmodule : tcd_host_model
`default_nettype wire

// File: dv/threshold_compare_decimation_ctrl_tb.sv
// Purpose: Bench for tcd_ctrl
// Assumes: Host model makes all register cycles
// Notes: Expectations queued, checked at negedge
`timescale 1ns/10ps
`default_nettype none
module threshold_compare_decimation_ctrl_tb
  import tcd_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        cfg_unlocked;
  tcd_sample_t adc_in = '0;
  logic [7:0]  standby_current = '0;
  logic        invalid_mode = 1'b0;
  logic        main_path_on = 1'b1;
  tcd_limits_t warn2_limits = 16'h20E0;
  tcd_limits_t warn3_limits = 16'h0060;
  logic        channel_digital_output;
  logic        main_compare_out;
  logic [2:0]  warn_flags;
  tcd_sample_t decimated_sample_reg;
  int          n_errors = 0;
  int          comparisons = 0;
  int          seed = 32'hF08CD636;
  logic        p_rd = 1'b0;
  logic        p_v = 1'b0;
  logic        h = 1'b0;
  logic [7:0]  s;
  logic [10:0] sum;
  logic [15:0] qr[$];
  logic [3:0]  qc[$];
  logic [7:0]  qd[$];
  tcd_ctrl i_dut (.*);
  tcd_host_model i_host (.*);
  initial forever #10 mclk = ~mclk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    qr.push_back(e);
    i_host.acc(a, 16'h0, 1'b0, 1'b1);
  endtask : rd
  task automatic samp(input logic [7:0] v);
    @(posedge mclk);
    #1;
    adc_in = {v, 1'b1};
    @(posedge mclk);
    #1;
    adc_in = {~v, 1'b0};
    @(posedge mclk);
    #1;
  endtask : samp
  function automatic logic cf(input logic [1:0] m, input logic [7:0] v, lo, hi, input logic p);
    case (m)
      2'h0: return v > hi ? 1'b1 : v <= lo ? 1'b0 : p;
      2'h1: return v > lo && v < hi;
      2'h2: return v > hi;
      default: return v <= hi;
    endcase
  endfunction : cf
  always @(posedge mclk) begin
    p_rd <= reg_rd;
    p_v <= adc_in.valid;
  end
  always @(negedge mclk) begin
    if (p_rd) chk(reg_rdata, qr.pop_front());
    if (p_v && qc.size() > 0) chk({warn_flags, main_compare_out}, qc.pop_front());
    if (decimated_sample_reg.valid) chk(decimated_sample_reg.value, qd.pop_front());
  end
  task automatic print_verdict();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(i < 3 ? 10'(i + 2) : 10'(i + 11), i == 0 ? 16'h3610 : i == 1 ? 16'h5AAA : i == 2 ? 16'hCCCC : 16'h0);
    end
    i_host.acc(10'h002, 16'hFFFF, 1'b1, 1'b0);
    rd(10'h002, 16'h3610);
    i_host.acc(10'h002, 16'hFFFF, 1'b1, 1'b1);
    rd(10'h002, 16'h7FFF);
    i_host.acc(10'h003, 16'h4080, 1'b1, 1'b1);
    rd(10'h003, 16'h4080);
    $display("registers done");
    for (int m = 0; m < 8; m++) begin
      i_host.acc(10'h002, 16'h3610 | 16'(m[2]) << 14 | 16'(m[1:0]) << 6, 1'b1, 1'b1);
      for (int i = 0; i < 12; i++) begin
        s = i == 0 ? 8'h40 : i == 1 ? 8'h80 : i == 2 ? 8'h41 : 8'($random(seed));
        standby_current = 8'($random(seed));
        main_path_on = i != 5;
        h = cf(m[1:0], m[2] ? standby_current : s, 8'h40, 8'h80, h);
        qc.push_back({cf(2'h3, s, 0, 8'h60, 0), cf(2'h1, s, 8'h20, 8'hE0, 0), cf(2'h2, s, 0, 8'hCC, 0), h && main_path_on});
        samp(s);
      end
    end
    $display("comparators done");
    for (int k = 0; k < 4; k++) begin
      i_host.acc(10'h002, 16'h3680 | 16'(k) << 4, 1'b1, 1'b1);
      samp(8'hFF);
      invalid_mode = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(channel_digital_output, k[0]);
      samp(8'h00);
      chk(channel_digital_output, k == 3);
      invalid_mode = 1'b0;
    end
    $display("invalid modes done");
    for (int r = 0; r < 4; r++) begin
      i_host.acc(10'h002, 16'h3611 | 16'(r) << 1, 1'b1, 1'b1);
      sum = '0;
      for (int i = 0; i < (1 << r); i++) begin
        s = 8'($random(seed));
        sum += s;
        if (i == (1 << r) - 1) qd.push_back(8'(sum >> r));
        samp(s);
      end
    end
    rd(10'h00F, {8'h00, 8'(sum >> 3)});
    rd(10'h00E, {8'h00, s});
    $display("decimation done");
    repeat (3) @(posedge mclk);
    chk(16'(qr.size() + qc.size() + qd.size()), 16'h0);
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule : threshold_compare_decimation_ctrl_tb
bind tcd_ctrl tcd_ctrl_properties i_chk (.*);
`default_nettype wire

// File: src/tcd_ctrl.sv
// Purpose: Comparator, output select and decimation control of one input channel
// Assumes: Lock, SPI framing, debounce and warning 2/3 limit registers live outside
// Notes: Register reads answer one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "tcd_consts.svh"

module tcd_ctrl
  import tcd_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [9:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic               cfg_unlocked,
  // Sample inputs
  input  wire tcd_sample_t        adc_in,
  input  wire logic [SAMPLE_W-1:0] standby_current,
  // Channel context
  input  wire logic               invalid_mode,
  input  wire logic               main_path_on,
  input  wire tcd_limits_t        warn2_limits,
  input  wire tcd_limits_t        warn3_limits,
  // Results
  output logic                    channel_digital_output,
  output logic                    main_compare_out,
  output logic      [2:0]         warn_flags,
  output tcd_sample_t             decimated_sample_reg
);

  localparam int NCH = 4;

  logic [15:0]         ctrl;
  tcd_limits_t         main_thr;
  tcd_limits_t         warn1_thr;
  logic [SAMPLE_W-1:0] raw_sample;

  tcd_limits_t         limits   [NCH];
  tcd_cmp_mode_t       modes    [NCH];
  logic [SAMPLE_W-1:0] cmp_in   [NCH];
  logic [NCH-1:0]      cmp_q;

  logic                load_standby;
  tcd_inv_mode_t       inv_sel;
  logic                fault_output_level;
  logic [1:0]          decimation_ratio;
  logic                decimation_on;

  logic                invalid_q;
  logic                invalid_entry;
  logic                held_level;
  logic                main_bit;
  logic                next_dout;

  logic [SAMPLE_W+2:0] dec_acc;
  logic [2:0]          dec_cnt;
  logic [2:0]          dec_last;
  logic [SAMPLE_W+2:0] dec_sum;

  // Control field decode
  assign load_standby       = ctrl[`TCD_POS_STANDBY];
  assign inv_sel            = tcd_inv_mode_t'(ctrl[`TCD_POS_INV_MODE +: 2]);
  assign fault_output_level = ctrl[`TCD_POS_FORCE_LVL];
  assign decimation_ratio   = ctrl[`TCD_POS_DEC_RATIO +: 2];
  assign decimation_on      = ctrl[`TCD_POS_DEC_ON];

  assign modes[0] = tcd_cmp_mode_t'(ctrl[`TCD_POS_MAIN_MODE +: 2]);
  assign modes[1] = tcd_cmp_mode_t'(ctrl[`TCD_POS_WARN1_MODE +: 2]);
  assign modes[2] = tcd_cmp_mode_t'(ctrl[`TCD_POS_WARN2_MODE +: 2]);
  assign modes[3] = tcd_cmp_mode_t'(ctrl[`TCD_POS_WARN3_MODE +: 2]);

  assign limits[0] = main_thr;
  assign limits[1] = warn1_thr;
  assign limits[2] = warn2_limits;
  assign limits[3] = warn3_limits;

  // Main comparator may watch the standby current instead of the ADC
  assign cmp_in[0] = load_standby ? standby_current : adc_in.value;
  assign cmp_in[1] = adc_in.value;
  assign cmp_in[2] = adc_in.value;
  assign cmp_in[3] = adc_in.value;

  // Control register; writes are accepted only while cfg_unlocked is high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `TCD_RST_CTRL;
    end else if (reg_wr && cfg_unlocked && reg_addr == `TCD_OFF_CTRL) begin
      ctrl <= reg_wdata & `TCD_CTRL_WMASK;
    end
  end

  // Threshold pairs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      main_thr  <= tcd_limits_t'(`TCD_RST_MAIN_THR);
      warn1_thr <= tcd_limits_t'(`TCD_RST_WARN1_THR);
    end else if (reg_wr && cfg_unlocked) begin
      if (reg_addr == `TCD_OFF_MAIN_THR) begin
        main_thr <= tcd_limits_t'(reg_wdata);
      end
      if (reg_addr == `TCD_OFF_WARN1_THR) begin
        warn1_thr <= tcd_limits_t'(reg_wdata);
      end
    end
  end

  // Comparators; evaluated only on a sample, so new settings apply next sample
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_cmp
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_q[gi] <= 1'b0;
        end else if (adc_in.valid) begin
          unique case (modes[gi])
            TCD_HYST: begin
              if (cmp_in[gi] > limits[gi].high) begin
                cmp_q[gi] <= 1'b1;
              end else if (cmp_in[gi] <= limits[gi].low) begin
                cmp_q[gi] <= 1'b0;
              end
            end
            TCD_WINDOW: begin
              cmp_q[gi] <= (cmp_in[gi] > limits[gi].low) &&
                           (cmp_in[gi] < limits[gi].high);
            end
            TCD_ABOVE: begin
              cmp_q[gi] <= cmp_in[gi] > limits[gi].high;
            end
            TCD_BELOW: begin
              cmp_q[gi] <= cmp_in[gi] <= limits[gi].high;
            end
          endcase
        end
      end
    end
  endgenerate

  // Disabled path forces the main result low at once, not at the next sample
  assign main_bit         = cmp_q[0] & main_path_on;
  assign main_compare_out = main_bit;
  assign warn_flags       = cmp_q[3:1];

  // Invalid-mode entry detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      invalid_q <= 1'b0;
    end else begin
      invalid_q <= invalid_mode;
    end
  end

  assign invalid_entry = invalid_mode & ~invalid_q;

  // Level captured once at entry, so a late mode change cannot re-toggle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      held_level <= 1'b0;
    end else if (invalid_entry) begin
      held_level <= (inv_sel == TCD_INV_TOGGLE) ? ~channel_digital_output
                                                : channel_digital_output;
    end
  end

  always_comb begin
    next_dout = main_bit;
    if (invalid_mode) begin
      unique case (inv_sel)
        TCD_INV_FORCE:  next_dout = fault_output_level;
        TCD_INV_FILTER: next_dout = main_bit;
        TCD_INV_TOGGLE: next_dout = invalid_entry ? ~channel_digital_output
                                                  : held_level;
        TCD_INV_HOLD:   next_dout = invalid_entry ? channel_digital_output
                                                  : held_level;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_digital_output <= 1'b0;
    end else begin
      channel_digital_output <= next_dout;
    end
  end

  // Raw sample capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      raw_sample <= '0;
    end else if (adc_in.valid) begin
      raw_sample <= adc_in.value;
    end
  end

  // Decimator: block average over 1 (bypass), 2, 4 or 8 samples
  assign dec_last = 3'((4'h1 << decimation_ratio) - 4'h1);
  assign dec_sum  = dec_acc + (SAMPLE_W+3)'(adc_in.value);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dec_acc <= '0;
      dec_cnt <= '0;
    end else if (!decimation_on) begin
      dec_acc <= '0;
      dec_cnt <= '0;
    end else if (adc_in.valid) begin
      if (dec_cnt == dec_last) begin
        dec_acc <= '0;
        dec_cnt <= '0;
      end else begin
        dec_acc <= dec_sum;
        dec_cnt <= dec_cnt + 3'h1;
      end
    end
  end

  // Separate result register; raw register is untouched by decimation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      decimated_sample_reg <= '0;
    end else begin
      decimated_sample_reg.valid <= 1'b0;
      if (decimation_on && adc_in.valid && dec_cnt == dec_last) begin
        decimated_sample_reg.value <= SAMPLE_W'(dec_sum >> decimation_ratio);
        decimated_sample_reg.valid <= 1'b1;
      end
    end
  end

  // Read port; reads never depend on the lock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TCD_OFF_CTRL:       reg_rdata <= ctrl;
        `TCD_OFF_MAIN_THR:   reg_rdata <= main_thr;
        `TCD_OFF_WARN1_THR:  reg_rdata <= warn1_thr;
        `TCD_OFF_RAW_SAMPLE: reg_rdata <= 16'(raw_sample);
        `TCD_OFF_DEC_SAMPLE: reg_rdata <= 16'(decimated_sample_reg.value);
        default:             reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule : tcd_ctrl
`default_nettype wire
